//--- shared/ssm_pkg.sv
`default_nettype none

package ssm_pkg;

  // shift clock division ratios, full period in system clocks
  localparam int unsigned DIV_SLOW = 12;
  localparam int unsigned DIV_FAST = 4;

  // half-period lengths derived from the ratios, the counter reloads one less
  localparam logic [2:0] HALF_SLOW = 3'(DIV_SLOW / 2);
  localparam logic [2:0] HALF_FAST = 3'(DIV_FAST / 2);

  // mode pattern {high, mid, low} that selects the spi master
  localparam logic [2:0] MODE_SPI = 3'h4;

  // bits in one transfer, and the index of the last one
  localparam int unsigned XFER_BITS = 8;
  localparam logic [2:0]  LAST_BIT  = 3'(XFER_BITS - 1);

  // values after reset
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [2:0] COUNT_RESET = 3'h0;

  // software configuration bits
  typedef struct packed {
    logic baud_timer_source_select;
    logic shift_speed_select;
    logic mode_select_high;
    logic bit_order_select;
    logic mode_select_mid;
    logic mode_select_low;
  } ssm_cfg_t;

  // bit order defaults to lsb first, every other bit to zero
  localparam ssm_cfg_t CFG_RESET = '{
    baud_timer_source_select: 1'b0,
    shift_speed_select:       1'b0,
    mode_select_high:         1'b0,
    bit_order_select:         1'b1,
    mode_select_mid:          1'b0,
    mode_select_low:          1'b0
  };

  // one driven pin: level and active-low output enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } ssm_pin_t;

  localparam ssm_pin_t PIN_RESET = '{out: 1'b0, oe_n: 1'b1};

  // transfer sequencer states
  typedef enum logic [1:0] {
    SSM_IDLE,
    SSM_LEAD,
    SSM_TRAIL
  } ssm_state_t;

endpackage

`default_nettype wire

//--- src/ssm_spi_master.sv
// Overview of operation
// - mode bits one, zero, zero select spi master; patterns five to seven unused
// - shift clock is system clock over 12, or over 4 when speed bit set
// - clock on transmit pin, data out on receive pin, data in on input pin
// - writable bit order control, reset value 1 means lsb first
// - any buffer write in spi mode starts a transfer
// - written byte shifts out serially while shift clock runs
// - transmit done flag sets after eight shift clock periods
// - input pin sampled into shift register, received byte read from buffer
// - receive done flag never set in spi master mode
// - timer select bit routes second port baud timer to uart modes 1, 3
`default_nettype none

module ssm_spi_master
  import ssm_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      cfg_wr,
  input  wire ssm_cfg_t  cfg_wdata,
  output var  ssm_cfg_t  cfg_q,
  input  wire logic      buf_wr,
  input  wire logic [7:0] buf_wdata,
  output logic     [7:0] buf_rdata,
  input  wire logic      tx_latch,
  input  wire logic      tx_done_clear,
  output logic           transmit_done_flag,
  input  wire logic      rx_done_set,
  input  wire logic      rx_done_clear,
  output logic           receive_done_flag,
  output logic           busy,
  input  wire logic      timer1_ovf,
  input  wire logic      brt_ovf,
  output logic           uart_baud_tick,
  output var  ssm_pin_t  serial_tx_pin,
  output var  ssm_pin_t  serial_rx_pin,
  input  wire logic      master_input_pin
);

  ssm_cfg_t   next_cfg;
  ssm_state_t state;
  ssm_state_t next_state;
  logic [2:0] half_cnt;
  logic [2:0] next_half_cnt;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic       rx_bit;
  logic       next_rx_bit;
  logic [7:0] next_buf_rdata;
  logic       next_busy;
  logic       done_pulse;
  logic       next_tdone;
  logic       next_rdone;
  logic       next_baud_tick;
  ssm_pin_t   next_tx_pin;
  ssm_pin_t   next_rx_pin;
  logic       miso_meta;
  logic       miso_sync;
  logic       spi_mode;
  logic [2:0] half_len;
  logic [2:0] half_reload;
  logic       lsb_first;

  // input pin comes from outside, two flops before any use
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
    end
    else
    begin
      miso_meta <= master_input_pin;
      miso_sync <= miso_meta;
    end
  end

  // configuration register, software written
  always_comb
  begin
    next_cfg = cfg_q;
    if (cfg_wr)
      next_cfg = cfg_wdata;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cfg_q <= CFG_RESET;
    else
      cfg_q <= next_cfg;
  end

  // reserved patterns five to seven simply leave the engine off
  assign spi_mode = ({cfg_q.mode_select_high, cfg_q.mode_select_mid,
                      cfg_q.mode_select_low} == MODE_SPI);
  assign half_len = cfg_q.shift_speed_select ? HALF_FAST : HALF_SLOW;
  assign half_reload = 3'(half_len - 3'h1);
  assign lsb_first = cfg_q.bit_order_select;

  // transfer sequencer: lead half makes the edge, trail half samples and shifts
  always_comb
  begin
    next_state     = state;
    next_half_cnt  = half_cnt;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_rx_bit    = rx_bit;
    next_buf_rdata = buf_rdata;
    next_tx_pin    = serial_tx_pin;
    next_rx_pin    = serial_rx_pin;
    done_pulse     = 1'b0;
    // pins belong to the uart logic outside this mode
    next_tx_pin.oe_n = ~spi_mode;
    next_rx_pin.oe_n = ~spi_mode;
    if (!spi_mode)
    begin
      next_state      = SSM_IDLE;
      next_tx_pin.out = tx_latch;
    end
    else if (buf_wr)
    begin
      // a write mid-transfer restarts with the new byte
      next_state      = SSM_LEAD;
      next_half_cnt   = half_reload;
      next_bit_cnt    = COUNT_RESET;
      next_shreg      = buf_wdata;
      next_tx_pin.out = tx_latch;
      next_rx_pin.out = lsb_first ? buf_wdata[0] : buf_wdata[7];
    end
    else
    begin
      case (state)
        SSM_IDLE:
        begin
          next_tx_pin.out = tx_latch;
        end
        SSM_LEAD:
        begin
          if (half_cnt == COUNT_RESET)
          begin
            next_tx_pin.out = ~tx_latch;
            next_state      = SSM_TRAIL;
            next_half_cnt   = half_reload;
          end
          else
            next_half_cnt = 3'(half_cnt - 3'h1);
        end
        SSM_TRAIL:
        begin
          if (half_cnt == COUNT_RESET)
          begin
            next_tx_pin.out = tx_latch;
            // synchroniser lags two clocks: the bit seen at the leading edge
            // only shows here, sampling at the edge would miss it at speed 1
            next_rx_bit     = miso_sync;
            // shift out moves the next bit onto the data pin
            if (lsb_first)
            begin
              next_shreg      = {miso_sync, shreg[7:1]};
              next_rx_pin.out = shreg[1];
            end
            else
            begin
              next_shreg      = {shreg[6:0], miso_sync};
              next_rx_pin.out = shreg[6];
            end
            if (bit_cnt == LAST_BIT)
            begin
              next_state     = SSM_IDLE;
              done_pulse     = 1'b1;
              next_buf_rdata = next_shreg;
            end
            else
            begin
              next_state    = SSM_LEAD;
              next_bit_cnt  = 3'(bit_cnt + 3'h1);
              next_half_cnt = half_reload;
            end
          end
          else
            next_half_cnt = 3'(half_cnt - 3'h1);
        end
        default:
        begin
          next_state = SSM_IDLE;
        end
      endcase
    end
    next_busy = (next_state != SSM_IDLE);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state         <= SSM_IDLE;
      half_cnt      <= COUNT_RESET;
      bit_cnt       <= COUNT_RESET;
      shreg         <= RDATA_RESET;
      rx_bit        <= 1'b0;
      buf_rdata     <= RDATA_RESET;
      busy          <= 1'b0;
      serial_tx_pin <= PIN_RESET;
      serial_rx_pin <= PIN_RESET;
    end
    else
    begin
      state         <= next_state;
      half_cnt      <= next_half_cnt;
      bit_cnt       <= next_bit_cnt;
      shreg         <= next_shreg;
      rx_bit        <= next_rx_bit;
      buf_rdata     <= next_buf_rdata;
      busy          <= next_busy;
      serial_tx_pin <= next_tx_pin;
      serial_rx_pin <= next_rx_pin;
    end
  end

  // flags: a set in the clearing cycle wins
  always_comb
  begin
    next_tdone = (transmit_done_flag & ~tx_done_clear) | done_pulse;
    next_rdone = (receive_done_flag & ~rx_done_clear)
                 | (rx_done_set & ~spi_mode);
    // overflow source for uart modes 1 and 3 when timer 1 is chosen
    next_baud_tick = cfg_q.baud_timer_source_select ? brt_ovf : timer1_ovf;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      transmit_done_flag <= 1'b0;
      receive_done_flag  <= 1'b0;
      uart_baud_tick     <= 1'b0;
    end
    else
    begin
      transmit_done_flag <= next_tdone;
      receive_done_flag  <= next_rdone;
      uart_baud_tick     <= next_baud_tick;
    end
  end

  // checks on the running design
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic quiet;
  assign quiet = spi_mode & ~buf_wr & ~cfg_wr;

  sequence s_trail_entry;
    state == SSM_LEAD && half_cnt == COUNT_RESET && quiet;
  endsequence

  sequence s_trail_slow;
    s_trail_entry ##0 !cfg_q.shift_speed_select ##1 quiet [*6];
  endsequence

  sequence s_trail_fast;
    s_trail_entry ##0 cfg_q.shift_speed_select ##1 quiet [*2];
  endsequence

  a_pins_enabled: assert property (spi_mode |=> !serial_tx_pin.oe_n && !serial_rx_pin.oe_n)
    else $error("spi pins not driven in master mode");

  a_slow_half: assert property (s_trail_slow |-> state == SSM_TRAIL ##1 state != SSM_TRAIL)
    else $error("slow half period is not six clocks");

  a_fast_half: assert property (s_trail_fast |-> state == SSM_TRAIL ##1 state != SSM_TRAIL)
    else $error("fast half period is not two clocks");

  a_write_starts: assert property (buf_wr && spi_mode |=> state == SSM_LEAD && bit_cnt == 3'h0)
    else $error("buffer write did not start a transfer");

  a_first_bit: assert property (buf_wr && spi_mode && !cfg_wr |=>
      serial_rx_pin.out == (cfg_q.bit_order_select ? $past(buf_wdata[0]) : $past(buf_wdata[7])))
    else $error("first data bit has the wrong order");

  a_done_eight: assert property (done_pulse |-> bit_cnt == 3'h7 && state == SSM_TRAIL
      ##1 transmit_done_flag && !busy)
    else $error("done flag not set after eighth bit");

  a_rx_capture: assert property (done_pulse && lsb_first |=> buf_rdata[7] == rx_bit)
    else $error("last sampled bit missing from buffer");

  a_no_rx_flag: assert property (spi_mode && !receive_done_flag |=> !receive_done_flag)
    else $error("receive flag set in spi master mode");

  a_baud_source: assert property (cfg_q.baud_timer_source_select && brt_ovf
      |=> uart_baud_tick)
    else $error("second port baud timer not routed");

  a_idle_clock: assert property (state == SSM_IDLE && spi_mode && !buf_wr
      |=> serial_tx_pin.out == $past(tx_latch))
    else $error("idle clock pin differs from latch");

endmodule

`default_nettype wire

//--- sim/ssm_spi_slave.sv
`default_nettype none

module ssm_spi_slave
(
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       cpol,
  input  wire logic       lsb,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte,
  output logic      [3:0] n_lead
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] idx;
  logic       bit_q = 1'b0;

  function automatic logic pick(input logic [2:0] i);
    return lsb ? tx_byte[i] : tx_byte[3'h7 - i];
  endfunction

  // first bit is ready as soon as we are selected
  always @(negedge sel_n)
  begin
    idx = 3'h0;
    n_lead = 4'h0;
    bit_q = pick(3'h0);
  end

  // sample on the leading edge, move on at the trailing one
  always @(sclk)
  begin
    if (!sel_n && sclk != cpol)
    begin
      rx_byte = {rx_byte[6:0], mosi};
      n_lead = n_lead + 4'h1;
    end
    else if (!sel_n)
    begin
      idx = idx + 3'h1;
      bit_q = pick(idx);
    end
  end

  // released line flips so a stale bit cannot pass
  assign miso = sel_n ? ~bit_q : bit_q;
endmodule

`default_nettype wire

//--- sim/ssm_spi_master_tb.sv
`default_nettype none

module ssm_spi_master_tb;
  import ssm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk = 1'b0;
  logic       rst, cfg_wr, buf_wr, tx_latch, tx_done_clear, rx_done_set, rx_done_clear;
  logic       timer1_ovf, brt_ovf, miso, sel_n, lsb, transmit_done_flag;
  logic       receive_done_flag, busy, uart_baud_tick;
  logic [7:0] buf_wdata, buf_rdata, slv_tx, slv_rx;
  logic [3:0] n_lead;
  ssm_cfg_t   cfg_wdata, cfg_q;
  ssm_pin_t   serial_tx_pin, serial_rx_pin;
  int         n_errors, compares;

  // 40 MHz system clock
  always #12.5 mclk = ~mclk;

  ssm_spi_master ssm_spi_master_inst (.mclk(mclk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_q(cfg_q), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
    .buf_rdata(buf_rdata), .tx_latch(tx_latch), .tx_done_clear(tx_done_clear),
    .transmit_done_flag(transmit_done_flag), .rx_done_set(rx_done_set),
    .rx_done_clear(rx_done_clear), .receive_done_flag(receive_done_flag), .busy(busy),
    .timer1_ovf(timer1_ovf), .brt_ovf(brt_ovf), .uart_baud_tick(uart_baud_tick),
    .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin),
    .master_input_pin(miso));

  ssm_spi_slave ssm_spi_slave_inst (.sclk(serial_tx_pin.out), .mosi(serial_rx_pin.out),
    .sel_n(sel_n), .cpol(tx_latch), .lsb(lsb), .tx_byte(slv_tx), .miso(miso),
    .rx_byte(slv_rx), .n_lead(n_lead));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev[i] = v[7 - i];
  endfunction

  // config write, then wait until the pin enables follow
  task automatic setcfg(input logic [2:0] m, input logic spd, ord, u);
    @(negedge mclk);
    cfg_wdata = {u, spd, m[2], ord, m[1:0]};
    cfg_wr = 1'b1;
    @(negedge mclk);
    cfg_wr = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  // write the buffer and count cycles to the done flag
  task automatic wr_wait(input logic [7:0] d, output int n);
    buf_wdata = d;
    buf_wr = 1'b1;
    rx_done_set = 1'b1;
    @(negedge mclk);
    buf_wr = 1'b0;
    rx_done_set = 1'b0;
    n = 0;
    while (transmit_done_flag !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic t_reset;
    chk({2'h0, cfg_q}, {2'h0, CFG_RESET});
    chk({4'h0, serial_tx_pin, serial_rx_pin}, 8'h05);
    chk({6'h0, transmit_done_flag, receive_done_flag}, 8'h00);
    $display("reset test done");
  endtask

  task automatic xfer(input logic spd, ord, pol, input logic [7:0] d, s);
    int n;
    tx_latch = pol;
    lsb = ord;
    slv_tx = s;
    setcfg(3'h4, spd, ord, 1'b0);
    chk({5'h0, serial_tx_pin, serial_rx_pin.oe_n}, {5'h0, pol, 2'h0});
    sel_n = 1'b0;
    wr_wait(d, n);
    chk(8'(n), spd ? 8'h20 : 8'h60);
    chk(buf_rdata, s);
    chk(slv_rx, ord ? rev(d) : d);
    chk({4'h0, n_lead}, 8'h08);
    chk({5'h0, busy, receive_done_flag, serial_tx_pin.out}, {7'h0, pol});
    sel_n = 1'b1;
    tx_done_clear = 1'b1;
    @(negedge mclk);
    tx_done_clear = 1'b0;
    @(negedge mclk);
    chk({7'h0, transmit_done_flag}, 8'h00);
    $display("transfer test done");
  endtask

  // a second write mid-transfer restarts the count
  task automatic t_restart;
    int n;
    buf_wdata = 8'h3c;
    buf_wr = 1'b1;
    @(negedge mclk);
    buf_wr = 1'b0;
    repeat (20) @(negedge mclk);
    chk({7'h0, busy}, 8'h01);
    wr_wait(8'hc3, n);
    chk(8'(n), 8'h60);
    tx_done_clear = 1'b1;
    @(negedge mclk);
    tx_done_clear = 1'b0;
    @(negedge mclk);
    chk({7'h0, transmit_done_flag}, 8'h00);
    $display("restart test done");
  endtask

  task automatic t_off;
    for (int m = 0; m < 8; m++)
    begin
      if (m == 4)
        continue;
      setcfg(3'(m), 1'b1, 1'b1, 1'b0);
      buf_wdata = 8'ha5;
      buf_wr = 1'b1;
      @(negedge mclk);
      buf_wr = 1'b0;
      repeat (40) @(negedge mclk);
      chk({5'h0, serial_tx_pin.oe_n, serial_rx_pin.oe_n, transmit_done_flag}, 8'h06);
    end
    $display("mode test done");
  endtask

  task automatic t_baud;
    for (int u = 0; u < 2; u++)
    begin
      setcfg(3'h1, 1'b0, 1'b1, 1'(u));
      for (int p = 1; p < 3; p++)
      begin
        {brt_ovf, timer1_ovf} = 2'(p);
        @(negedge mclk);
        {brt_ovf, timer1_ovf} = 2'h0;
        chk({7'h0, uart_baud_tick}, {7'h0, (u == 1) == (p == 2)});
      end
    end
    // outside spi mode the receive flag must still be settable
    rx_done_set = 1'b1;
    @(negedge mclk);
    rx_done_set = 1'b0;
    chk({7'h0, receive_done_flag}, 8'h01);
    rx_done_clear = 1'b1;
    @(negedge mclk);
    rx_done_clear = 1'b0;
    chk({7'h0, receive_done_flag}, 8'h00);
    $display("baud test done");
  endtask

  task automatic report_and_stop;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {rst, cfg_wr, buf_wr, tx_latch, tx_done_clear, rx_done_set} = 6'h20;
    {rx_done_clear, timer1_ovf, brt_ovf, lsb, sel_n} = 5'h01;
    cfg_wdata = CFG_RESET;
    buf_wdata = 8'h00;
    slv_tx = 8'h00;
    n_errors = 0;
    compares = 0;
    repeat (16) @(negedge mclk);
    t_reset();
    rst = 1'b0;
    xfer(1'b0, 1'b1, 1'b0, 8'h96, 8'h4b);
    xfer(1'b0, 1'b0, 1'b1, 8'h1e, 8'hc2);
    xfer(1'b1, 1'b1, 1'b0, 8'h81, 8'h69);
    setcfg(3'h4, 1'b0, 1'b1, 1'b0);
    t_restart();
    t_off();
    t_baud();
    report_and_stop();
  end

  // watchdog well beyond the expected run of under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire
